// file: design/smc_defs.svh
/*
 * Constants of the serial port mode and timing block: bit positions inside the
 * control and format words, word length, fixed timing extras and clock rate.
 * Assumes it is included by bare name from each design file that needs it.
 */
`ifndef SMC_DEFS_SVH
`define SMC_DEFS_SVH

// ****************************************************************
// Field positions.
// ****************************************************************
`define SMC_CTRL_SEL_BIT 0
`define SMC_PHASE_BIT 16
`define SMC_POL_BIT 17
`define SMC_PS_MSB 15
`define SMC_PS_LSB 8

// ****************************************************************
// Transfer shape and reset values.
// ****************************************************************
`define SMC_WORD_BITS 16
`define SMC_LAST_EDGE 5'h1F
`define SMC_SETUP_EXTRA 9'h002
`define SMC_HOLD_EXTRA 9'h001
`define SMC_RST_WORD 16'h0000

// ****************************************************************
// Timing: the figures in ns and the cycle counts derived from them.
// ****************************************************************
`define SMC_CLK_NS 20
`define SMC_MIN_PERIOD_NS 25
`define SMC_MIN_PERIOD_CYC ((`SMC_MIN_PERIOD_NS + `SMC_CLK_NS - 1) / `SMC_CLK_NS)

`endif

// file: design/smc_pkg.sv
/*
 * Types and shared arithmetic of the serial port mode and timing block.
 * Assumes smc_defs.svh is on the include path.
 */
`include "smc_defs.svh"

package smc_pkg;

   // ****************************************************************
   // Controller sequencer states, one-hot.
   // ****************************************************************
   typedef enum logic [5:0] {
      SMC_IDLE = 6'b000001,
      SMC_SETUP = 6'b000010,
      SMC_PREHALF = 6'b000100,
      SMC_SHIFT = 6'b001000,
      SMC_POSTHALF = 6'b010000,
      SMC_HOLD = 6'b100000
   } smc_state_t;

   // Serial clock period in module clocks: prescale plus one, or two at zero.
   function automatic logic [8:0] smc_period(input logic [7:0] ps);
      smc_period = (ps == 8'h00) ? 9'h002 : ({1'b0, ps} + 9'h001);
   endfunction

endpackage

// file: design/smc_half_gen.sv
/*
 * Half-period strobe generator for the serial clock. While run is high it
 * pulses half_tick_out at the end of each half period; the first half takes
 * the floor of period/2, the second the rest, so odd periods stay whole.
 * Assumes one clock domain and a synchronous clock enable.
 */
`timescale 1ns/1ps

module smc_half_gen
   import smc_pkg::*;
(
   // Clock, reset and enable.
   input wire logic clk_sys_in,
   input wire logic rstn_in,
   input wire logic clk_en_in,
   // Control.
   input wire logic run_in,
   input wire logic [7:0] prescale_in,
   // Strobe.
   output logic half_tick_out
);

   logic [8:0] cnt;
   logic second;
   logic [8:0] period;
   logic [8:0] half_len;

   // Length of the half now running.
   always_comb begin
      period = smc_period(prescale_in);
      half_len = second ? (period - {1'b0, period[8:1]}) : {1'b0, period[8:1]};
   end

   assign half_tick_out = run_in && (cnt == half_len - 9'h001);

   // Counter restarts whenever the sequencer stops, so each run is aligned.
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         cnt <= 9'h000;
         second <= 1'b0;
      end else if (clk_en_in) begin
         if (!run_in) begin
            cnt <= 9'h000;
            second <= 1'b0;
         end else if (half_tick_out) begin
            cnt <= 9'h000;
            second <= ~second;
         end else begin
            cnt <= cnt + 9'h001;
         end
      end
   end

endmodule // smc_half_gen

// file: design/smc_core.sv
/*
 * Mode, clock and chip-select timing of a 16-bit serial port that acts as
 * controller or peripheral. Holds one transmit word, shifts MSB first, and
 * returns each received word as a one-cycle strobe.
 * Assumes all pin inputs are synchronous to clk_sys_in and that software keeps
 * the role and format steady while a word is in flight.
 */
`timescale 1ns/1ps
`include "smc_defs.svh"

module smc_core
   import smc_pkg::*;
(
   // Clock, reset and enable.
   input wire logic clk_sys_in,
   input wire logic rstn_in,
   input wire logic clk_en_in,
   // Configuration words and delays.
   input wire logic [31:0] global_control_reg_in,
   input wire logic [31:0] format_reg_in,
   input wire logic [7:0] select_to_clock_delay_in,
   input wire logic [7:0] clock_to_select_delay_in,
   input wire logic select_hold_opt_in,
   // User word side.
   input wire logic word_valid_in,
   input wire logic [15:0] word_data_in,
   output logic word_ready_out,
   output logic rx_valid_out,
   output logic [15:0] rx_data_out,
   output logic busy_out,
   output logic period_ok_out,
   // Serial clock pin.
   input wire logic serial_clock_pin_in,
   output logic serial_clock_pin_out,
   output logic serial_clock_pin_oe_n_out,
   // Controller-out data pin.
   input wire logic ctrl_out_data_pin_in,
   output logic ctrl_out_data_pin_out,
   output logic ctrl_out_data_pin_oe_n_out,
   // Peripheral-out data pin.
   input wire logic periph_out_data_pin_in,
   output logic periph_out_data_pin_out,
   output logic periph_out_data_pin_oe_n_out,
   // Chip select pin, active low.
   input wire logic sel_n_pin_in,
   output logic sel_n_pin_out,
   output logic sel_n_pin_oe_n_out
);

   // ****************************************************************
   // Configuration decode.
   // ****************************************************************
   logic is_ctrl;
   logic phase;
   logic pol;
   logic [7:0] prescale;
   assign is_ctrl = global_control_reg_in[`SMC_CTRL_SEL_BIT];
   assign phase = format_reg_in[`SMC_PHASE_BIT];
   assign pol = format_reg_in[`SMC_POL_BIT];
   assign prescale = format_reg_in[`SMC_PS_MSB:`SMC_PS_LSB];

   // Status only: software owns keeping the period at or above the floor.
   assign period_ok_out = (smc_period(prescale) >= 9'(`SMC_MIN_PERIOD_CYC));

   // ****************************************************************
   // Declarations.
   // ****************************************************************
   smc_state_t state;
   smc_state_t next_state;
   logic [8:0] dcnt;
   logic [4:0] edge_cnt;
   logic sclk;
   logic sel_n;
   logic half_tick;
   logic run;
   logic setup_done;
   logic hold_done;
   logic [8:0] setup_len;
   logic c_edge;
   logic p_edge;
   logic any_edge;
   logic lead;
   logic sample;
   logic launch;
   logic din;
   logic sclk_q;
   logic sel_q;
   logic sel_fall;
   logic [15:0] tx_hold;
   logic tx_full;
   logic [15:0] tx_sh;
   logic [15:0] rx_sh;
   logic start;

   // ****************************************************************
   // Controller sequencer.
   // ****************************************************************
   assign run = (state == SMC_PREHALF) || (state == SMC_SHIFT) || (state == SMC_POSTHALF);

   smc_half_gen u_half_gen (
      .clk_sys_in(clk_sys_in),
      .rstn_in(rstn_in),
      .clk_en_in(clk_en_in),
      .run_in(run),
      .prescale_in(prescale),
      .half_tick_out(half_tick)
   );

   // Select-to-clock wait is delay plus two, one more with the hold option.
   assign setup_len = {1'b0, select_to_clock_delay_in} + `SMC_SETUP_EXTRA
      + {8'h00, select_hold_opt_in};
   assign setup_done = (dcnt == setup_len - 9'h001);
   assign hold_done = (dcnt == {1'b0, clock_to_select_delay_in});
   assign start = is_ctrl && tx_full && (state == SMC_IDLE);

   // Phase 0 fires its first edge as the setup wait ends; phase 1 fires it as the
   // extra half ends, so its lead is the setup wait plus the first half, the floor of period/2.
   assign c_edge = ((state == SMC_SETUP) && setup_done && !phase)
      || ((state == SMC_PREHALF) && half_tick)
      || ((state == SMC_SHIFT) && half_tick);

   // Next-state choice.
   always_comb begin
      next_state = state;
      unique case (state)
         SMC_IDLE: if (start) next_state = SMC_SETUP;
         SMC_SETUP: if (setup_done) next_state = phase ? SMC_PREHALF : SMC_SHIFT;
         SMC_PREHALF: if (half_tick) next_state = SMC_SHIFT;
         SMC_SHIFT: begin
            if (half_tick && edge_cnt == `SMC_LAST_EDGE) begin
               next_state = phase ? SMC_HOLD : SMC_POSTHALF;
            end
         end
         SMC_POSTHALF: if (half_tick) next_state = SMC_HOLD;
         SMC_HOLD: if (hold_done) next_state = SMC_IDLE;
         default: next_state = SMC_IDLE;
      endcase
   end

   // State register; dropping controller role abandons a word in flight.
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         state <= SMC_IDLE;
      end else if (clk_en_in) begin
         state <= is_ctrl ? next_state : SMC_IDLE;
      end
   end

   // Module-clock counter for the setup and hold waits.
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         dcnt <= 9'h000;
      end else if (clk_en_in) begin
         if (next_state != state) begin
            dcnt <= 9'h000;
         end else begin
            dcnt <= dcnt + 9'h001;
         end
      end
   end

   // Serial clock and select outputs of the controller.
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         sclk <= 1'b0;
         sel_n <= 1'b1;
      end else if (clk_en_in) begin
         if (state == SMC_IDLE || !is_ctrl) begin
            sclk <= pol;
         end else if (c_edge) begin
            sclk <= ~sclk;
         end
         if (start) begin
            sel_n <= 1'b0;
         end else if ((state == SMC_HOLD && hold_done) || !is_ctrl) begin
            sel_n <= 1'b1;
         end
      end
   end

   // ****************************************************************
   // Peripheral edge detection on the sampled pins.
   // ****************************************************************
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         sclk_q <= 1'b0;
         sel_q <= 1'b1;
      end else if (clk_en_in) begin
         sclk_q <= serial_clock_pin_in;
         sel_q <= sel_n_pin_in;
      end
   end

   // Each select fall starts a fresh 16-bit word, as the host must provide.
   assign sel_fall = !is_ctrl && sel_q && !sel_n_pin_in;
   assign p_edge = !is_ctrl && !sel_n_pin_in && !sel_q
      && (serial_clock_pin_in != sclk_q);

   // ****************************************************************
   // Shared shift path for both roles.
   // ****************************************************************
   assign any_edge = is_ctrl ? c_edge : p_edge;
   // Leading edge leaves the idle level; edge index parity says the same.
   assign lead = is_ctrl ? !edge_cnt[0] : (sclk_q == pol);
   assign sample = phase ? !lead : lead;
   assign launch = !sample && !(phase && edge_cnt == 5'h00)
      && (edge_cnt != `SMC_LAST_EDGE);
   assign din = is_ctrl ? periph_out_data_pin_in : ctrl_out_data_pin_in;

   // Edge index within the word.
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         edge_cnt <= 5'h00;
      end else if (clk_en_in) begin
         if (start || sel_fall || (!is_ctrl && sel_n_pin_in)) begin
            edge_cnt <= 5'h00;
         end else if (any_edge) begin
            edge_cnt <= edge_cnt + 5'h01;
         end
      end
   end

   // Transmit holding word; a peripheral sends zeros if none is waiting.
   assign word_ready_out = !tx_full;
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         tx_hold <= `SMC_RST_WORD;
         tx_full <= 1'b0;
      end else if (clk_en_in) begin
         if (word_valid_in && !tx_full) begin
            tx_hold <= word_data_in;
            tx_full <= 1'b1;
         end else if (start || sel_fall) begin
            tx_full <= 1'b0;
         end
      end
   end

   // Shift registers, most significant bit first.
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         tx_sh <= `SMC_RST_WORD;
         rx_sh <= `SMC_RST_WORD;
      end else if (clk_en_in) begin
         if (start || sel_fall) begin
            tx_sh <= tx_full ? tx_hold : `SMC_RST_WORD;
         end else if (any_edge && launch) begin
            tx_sh <= {tx_sh[14:0], 1'b0};
         end
         if (any_edge && sample) begin
            rx_sh <= {rx_sh[14:0], din};
         end
      end
   end

   // Received word strobe on the sixteenth sample.
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rx_valid_out <= 1'b0;
         rx_data_out <= `SMC_RST_WORD;
      end else if (clk_en_in) begin
         rx_valid_out <= 1'b0;
         if (any_edge && sample && (edge_cnt[4:1] == 4'hF)) begin
            rx_valid_out <= 1'b1;
            rx_data_out <= {rx_sh[14:0], din};
         end
      end
   end

   // ****************************************************************
   // Pin drive by role; enables are low while driving.
   // ****************************************************************
   assign busy_out = is_ctrl ? (state != SMC_IDLE) : !sel_n_pin_in;
   assign serial_clock_pin_out = sclk;
   assign serial_clock_pin_oe_n_out = !is_ctrl;
   assign sel_n_pin_out = sel_n;
   assign sel_n_pin_oe_n_out = !is_ctrl;
   assign ctrl_out_data_pin_out = tx_sh[15];
   assign ctrl_out_data_pin_oe_n_out = !is_ctrl;
   assign periph_out_data_pin_out = tx_sh[15];
   // Peripheral drives return data only while selected, so buses can share.
   assign periph_out_data_pin_oe_n_out = is_ctrl || sel_n_pin_in;

endmodule // smc_core

// file: test/smc_core_sva.sv
/* Checker of select and serial clock timing for smc_core.
   Assumes it is bound onto smc_core and that clk_en_in stays high. */
`timescale 1ns/1ps
module smc_core_sva (
   // Clock, reset and settings.
   input wire logic clk_sys_in, rstn_in, clk_en_in,
   input wire logic [31:0] global_control_reg_in, format_reg_in,
   input wire logic [7:0] select_to_clock_delay_in, clock_to_select_delay_in,
   input wire logic select_hold_opt_in,
   // Observed outputs and pins.
   input wire logic word_valid_in, word_ready_out, rx_valid_out, busy_out,
   input wire logic serial_clock_pin_out, serial_clock_pin_oe_n_out, sel_n_pin_out,
   input wire logic periph_out_data_pin_oe_n_out, sel_n_pin_in, sel_n_pin_oe_n_out,
   input wire logic ctrl_out_data_pin_oe_n_out
);
   logic ctl, pha, pol;
   logic [9:0] per, cnt, lc, ec, s2c, t2c, h1, h2;
   assign ctl = global_control_reg_in[0];
   assign pha = format_reg_in[16];
   assign pol = format_reg_in[17];
   assign per = (format_reg_in[15:8] == 8'h00) ? 10'h002 : {2'h0, format_reg_in[15:8]} + 10'h001;
   assign s2c = {2'h0, select_to_clock_delay_in} + {9'h000, select_hold_opt_in} + 10'h002;
   assign t2c = {2'h0, clock_to_select_delay_in} + 10'h001;
   assign h1 = per >> 1;
   assign h2 = per - h1;
   // Cycles with select low, so the lead before the first edge is measurable.
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) cnt <= 10'h000;
      else if (sel_n_pin_out) cnt <= 10'h000;
      else cnt <= cnt + 10'h001;
   end
   // Cycles since the last clock edge; saturates so it never wraps to a false match.
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) lc <= 10'h000;
      else if ($changed(serial_clock_pin_out)) lc <= 10'h001;
      else if (lc != 10'h3FF) lc <= lc + 10'h001;
   end
   // Clock edges seen within one select window.
   always_ff @(posedge clk_sys_in or negedge rstn_in) begin
      if (!rstn_in) ec <= 10'h000;
      else if (sel_n_pin_out) ec <= 10'h000;
      else if ($changed(serial_clock_pin_out)) ec <= ec + 10'h001;
   end
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!rstn_in);
   sequence s_first_edge;
      ctl && !sel_n_pin_out && ec == 10'h000 && $changed(serial_clock_pin_out);
   endsequence
   sequence s_release;
      ctl && $rose(sel_n_pin_out);
   endsequence
   a_sel_to_clock: assert property (s_first_edge |-> cnt == s2c + (pha ? h1 : 10'h000))
      else $error("select lead before first clock edge wrong");
   a_clock_to_sel: assert property (s_release |->
      (pha ? lc == t2c : (lc == h1 + t2c || lc == h2 + t2c)))
      else $error("select release after last clock edge wrong");
   a_edge_total: assert property (s_release |-> ec == 10'd32)
      else $error("edge count per word wrong");
   a_half_period: assert property (ctl && !sel_n_pin_out && ec != 10'h000 &&
      $changed(serial_clock_pin_out) |-> (lc == h1 || lc == h2))
      else $error("serial clock half period wrong");
   a_idle_level: assert property (ctl && !busy_out && $past(busy_out) == 1'b0 &&
      $past(rstn_in) && $past(pol) == pol && $past(ctl) == ctl |-> serial_clock_pin_out == pol)
      else $error("idle serial clock level wrong");
   a_role_pins: assert property (serial_clock_pin_oe_n_out == !ctl &&
      sel_n_pin_oe_n_out == !ctl && ctrl_out_data_pin_oe_n_out == !ctl)
      else $error("pin drive does not follow role");
   a_periph_drive: assert property (periph_out_data_pin_oe_n_out == (ctl || sel_n_pin_in))
      else $error("return data drive wrong");
   a_busy_periph: assert property (!ctl |-> busy_out == !sel_n_pin_in)
      else $error("peripheral busy wrong");
endmodule // smc_core_sva
bind smc_core smc_core_sva chk (.clk_sys_in, .rstn_in, .clk_en_in, .global_control_reg_in,
   .format_reg_in, .select_to_clock_delay_in, .clock_to_select_delay_in, .select_hold_opt_in,
   .word_valid_in, .word_ready_out, .rx_valid_out, .busy_out, .serial_clock_pin_out,
   .serial_clock_pin_oe_n_out, .sel_n_pin_out, .periph_out_data_pin_oe_n_out, .sel_n_pin_in,
   .sel_n_pin_oe_n_out, .ctrl_out_data_pin_oe_n_out);

// file: test/smc_peer.sv
/* External serial peripheral facing the port in controller role.
   Assumes clock and select come from the resolved pin wires. */
`timescale 1ns/1ps
module smc_peer (
   input wire logic sclk_in, sel_n_in, data_in, pha_in, pol_in,
   input wire logic [15:0] tx_in,
   output logic data_out,
   output logic [15:0] rx_out
);
   logic [15:0] sh = 16'h0000;
   initial data_out = 1'b0;
   initial rx_out = 16'h0000;
   // Select fall loads the word; in phase 0 the MSB must stand before any edge.
   always @(negedge sel_n_in) begin
      sh = pha_in ? tx_in : {tx_in[14:0], 1'b0};
      data_out = tx_in[15];
   end
   // A released line shows the inverse of its last level, not a stale value.
   always @(posedge sel_n_in) data_out = ~data_out;
   // Leading edge leaves the idle level; phase picks sample or launch on it.
   always @(sclk_in) begin
      if (!sel_n_in) begin
         if ((sclk_in != pol_in) != pha_in) rx_out = {rx_out[14:0], data_in};
         else begin
            data_out = sh[15];
            sh = {sh[14:0], 1'b0};
         end
      end
   end
endmodule // smc_peer

// file: test/test_spi_mode_clock_and_select_timing.sv
/* Self-checking bench of smc_core in both roles with a queue model of words.
   Assumes smc_peer and the bound checker are compiled alongside. */
`timescale 1ns/1ps
module test_spi_mode_clock_and_select_timing;
   logic clk_sys_in = 1'b0, rstn_in = 1'b0, clk_en_in = 1'b1;
   logic [31:0] global_control_reg_in = 32'h0, format_reg_in = 32'h0;
   logic [7:0] select_to_clock_delay_in = 8'h00, clock_to_select_delay_in = 8'h00;
   logic select_hold_opt_in = 1'b0, word_valid_in = 1'b0;
   logic [15:0] word_data_in = 16'h0000, rx_data_out, peer_tx = 16'h0000, peer_rx;
   logic word_ready_out, rx_valid_out, busy_out, period_ok_out, peer_d;
   logic sclk_o, sclk_oe_n, mosi_o, mosi_oe_n, miso_o, miso_oe_n, sel_n_o, sel_oe_n;
   logic h_clk = 1'b0, h_sel_n = 1'b1, h_mosi = 1'b0, tog = 1'b0;
   integer bad_count = 0, samples_checked = 0;
   logic [15:0] rxq[$], txq[$];
   // Each wire takes the level of whoever drives it.
   wire ctl = global_control_reg_in[0];
   wire sclk_w = sclk_oe_n ? h_clk : sclk_o;
   wire sel_n_w = sel_oe_n ? h_sel_n : sel_n_o;
   wire mosi_w = mosi_oe_n ? h_mosi : mosi_o;
   wire miso_w = miso_oe_n ? (ctl ? peer_d : tog) : miso_o;
   smc_core dut (.clk_sys_in, .rstn_in, .clk_en_in, .global_control_reg_in, .format_reg_in,
      .select_to_clock_delay_in, .clock_to_select_delay_in, .select_hold_opt_in,
      .word_valid_in, .word_data_in, .word_ready_out, .rx_valid_out, .rx_data_out,
      .busy_out, .period_ok_out, .serial_clock_pin_in(sclk_w), .serial_clock_pin_out(sclk_o),
      .serial_clock_pin_oe_n_out(sclk_oe_n), .ctrl_out_data_pin_in(mosi_w),
      .ctrl_out_data_pin_out(mosi_o), .ctrl_out_data_pin_oe_n_out(mosi_oe_n),
      .periph_out_data_pin_in(miso_w), .periph_out_data_pin_out(miso_o),
      .periph_out_data_pin_oe_n_out(miso_oe_n), .sel_n_pin_in(sel_n_w),
      .sel_n_pin_out(sel_n_o), .sel_n_pin_oe_n_out(sel_oe_n));
   smc_peer peer (.sclk_in(sclk_w), .sel_n_in(sel_n_w), .data_in(mosi_w),
      .pha_in(format_reg_in[16]), .pol_in(format_reg_in[17]), .tx_in(peer_tx),
      .data_out(peer_d), .rx_out(peer_rx));
   initial forever #10 clk_sys_in = ~clk_sys_in;
   task check(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR t=%0t got %h expected %h", $time, got, exp);
      end
   endtask
   task finish_test;
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // Holds the word offered until the one-word holder takes it.
   task send(input logic [15:0] w);
      word_valid_in <= 1'b1;
      word_data_in <= w;
      @(negedge clk_sys_in);
      while (word_ready_out !== 1'b1) @(negedge clk_sys_in);
      @(posedge clk_sys_in);
      word_valid_in <= 1'b0;
      // Let one edge pass so a following call never re-raises valid in this step.
      @(posedge clk_sys_in);
   endtask
   // Outside host with half periods of 4 clocks; one select window per word.
   task host(input logic [15:0] w, output logic [15:0] got);
      integer i;
      h_clk <= format_reg_in[17];
      @(posedge clk_sys_in);
      h_sel_n <= 1'b0;
      h_mosi <= w[15];
      repeat (16) @(posedge clk_sys_in);
      for (i = 15; i >= 0; i--) begin
         if (format_reg_in[16]) h_mosi <= w[i];
         h_clk <= ~format_reg_in[17];
         repeat (4) @(posedge clk_sys_in);
         got[i] = miso_w;
         h_clk <= format_reg_in[17];
         if (!format_reg_in[16] && i > 0) h_mosi <= w[i-1];
         repeat (4) @(posedge clk_sys_in);
      end
      h_sel_n <= 1'b1;
      repeat (4) @(posedge clk_sys_in);
   endtask
   // Received words are matched in order; the peer's capture at each release.
   always @(posedge clk_sys_in) begin
      tog <= ~tog;
      if (rx_valid_out === 1'b1) check(rx_data_out, rxq.size() ? rxq.pop_front() : 16'hXXXX);
   end
   always @(posedge sel_n_o) if (ctl && rstn_in) check(peer_rx, txq.pop_front());
   initial begin
      repeat (60000) @(posedge clk_sys_in);
      bad_count++;
      $display("ERROR t=%0t watchdog expired", $time);
      finish_test;
   end
   initial begin
      integer i, k, n;
      logic [15:0] w, hw, got;
      n = $urandom(32'hE3479269);
      repeat (8) @(posedge clk_sys_in);
      rstn_in <= 1'b1;
      // All four phase and polarity pairs, in both roles; prescale 255 once.
      for (i = 0; i < 4; i++) begin
         @(posedge clk_sys_in);
         format_reg_in <= {14'h0, i[1:0], (i == 3) ? 8'hFF : 8'($urandom % 3), 8'($urandom)};
         global_control_reg_in <= 32'h1;
         select_to_clock_delay_in <= 8'($urandom % 4);
         clock_to_select_delay_in <= 8'($urandom % 4);
         select_hold_opt_in <= 1'($urandom);
         peer_tx = 16'($urandom);
         for (k = 0; k < 2; k++) begin
            w = 16'($urandom);
            rxq.push_back(peer_tx);
            txq.push_back(w);
            send(w);
         end
         n = 0;
         while ((busy_out !== 1'b0 || word_ready_out !== 1'b1) && n < 20000) begin
            @(negedge clk_sys_in);
            n++;
         end
         if (n >= 20000) begin
            bad_count++;
            $display("ERROR t=%0t controller words never finished", $time);
         end
         repeat (4) @(posedge clk_sys_in);
         check({15'h0, period_ok_out}, 16'h0001);
         global_control_reg_in <= 32'h0;
         w = 16'($urandom);
         hw = 16'($urandom);
         send(w);
         rxq.push_back(hw);
         host(hw, got);
         check(got, w);
      end
      // Every expected word must have come back by now.
      check(16'(rxq.size() + txq.size()), 16'h0000);
      finish_test;
   end
endmodule // test_spi_mode_clock_and_select_timing
